// ### src/amc_pkg.sv
// Constants and types for the converter mode and input configuration block
// How it works
// R1 - Output timing register bit D3 flags a low input clock; default inactive.
// R2 - Early-shift bit emits serial data and frame clock one cycle earlier.
// R3 - Late-shift bit emits serial data and frame clock one cycle later.
// R4 - Host never writes addresses missing from the map.
// R5 - Host writes zero into every unassigned bit position.
// R6 - Writes are accepted and stored even during power-down.
// R7 - Host power-cycles after writing low-clock bit or start-up field.
// R8 - Writing one to reset bit restores all defaults, bit clears itself.
// R9 - Mode field: 001 single, 010 dual, 100 quad unsupported.
// R10 - Dual mode: cores one and two form channel one, three and four channel two.
// R11 - Host sets at most one mode bit.
// R12 - Host enters power-down during or after a mode change.
// R13 - Divider field 00, 01, 10 divides input clock by 1, 2, 4; 11 unused.
// R14 - Divider sits at D9:D8 of the mode register, default divide by one.
// R15 - Five-bit input select routes first input, two grounds or second input.
// R16 - Select fields at 0x3A and 0x3B with per-core defaults.
// R17 - Changed input selection applies right at the end of each command.
// R18 - Dual mode: host sets cores one, two to 00010, three, four to 10000.
// R19 - Single mode: host sets all cores alike, 00010 or 10000.
// R20 - Six-bit full-scale trim at D5:D0, default zero percent change.
// R21 - Each multi-bit field updates atomically when a serial write completes.
package amc_pkg;

    // ======================================================================
    // Serial frame
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 16;
    localparam int FRAME_BITS = 24;

    // ======================================================================
    // Register addresses
    localparam logic [7:0] ADDR_SOFT_RESET = 8'h00;
    localparam logic [7:0] ADDR_MODE       = 8'h31;
    localparam logic [7:0] ADDR_INSEL_A    = 8'h3A;
    localparam logic [7:0] ADDR_INSEL_B    = 8'h3B;
    localparam logic [7:0] ADDR_OUT_TIMING = 8'h53;
    localparam logic [7:0] ADDR_FS_TRIM    = 8'h55;
    localparam logic [7:0] ADDR_STARTUP    = 8'h56;

    // ======================================================================
    // Field positions
    localparam int SOFT_RESET_BIT = 0;
    localparam int LOW_CLK_BIT    = 3;
    localparam int EARLY_BIT      = 4;
    localparam int LATE_BIT       = 5;
    localparam int MODE_LSB       = 0;
    localparam int DIV_LSB        = 8;
    localparam int SEL_LO_LSB     = 0;
    localparam int SEL_HI_LSB     = 8;
    localparam int FS_LSB         = 0;
    localparam int STARTUP_LSB    = 0;

    // ======================================================================
    // Values after reset
    localparam logic [2:0] MODE_RST    = 3'h4;
    localparam logic [1:0] DIV_RST     = 2'h0;
    localparam logic [4:0] SEL1_RST    = 5'h02;
    localparam logic [4:0] SEL2_RST    = 5'h04;
    localparam logic [4:0] SEL3_RST    = 5'h04;
    localparam logic [4:0] SEL4_RST    = 5'h10;
    localparam logic [5:0] FS_RST      = 6'h20;
    localparam logic [2:0] STARTUP_RST = 3'h0;

    // ======================================================================
    // Encodings
    localparam logic [2:0] MODE_SINGLE = 3'h1;
    localparam logic [2:0] MODE_DUAL   = 3'h2;
    localparam logic [1:0] DIV_BY_1    = 2'h0;
    localparam logic [1:0] DIV_BY_2    = 2'h1;
    localparam logic [1:0] DIV_BY_4    = 2'h2;
    localparam logic [1:0] DIV_CNT_1   = 2'h0;
    localparam logic [1:0] DIV_CNT_2   = 2'h1;
    localparam logic [1:0] DIV_CNT_4   = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_HOLD  = 3'b100
    } amc_rx_state_t;

endpackage

// ### src/amc_config_top.sv
// Serial-programmed mode, divider, crosspoint and output timing configuration
`timescale 1ns/100ps
`default_nettype none

module amc_config_top
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Serial control pins
    input  wire logic       ser_sel_n,
    input  wire logic       ser_clk,
    input  wire logic       ser_data,
    // Power-down pin
    input  wire logic       power_down,
    // Serial output stream, same clock
    input  wire logic       stream_bit_in,
    input  wire logic       stream_frame_in,
    output logic            stream_bit_out,
    output logic            stream_frame_out,
    // Sampling clock
    output logic            sample_strobe,
    // Mode
    output logic            single_mode,
    output logic            dual_mode,
    output logic            mode_unsupported,
    output logic [3:0]      core_channel,
    // Crosspoint routes: one-hot, all zero for illegal codes {second, ground b, ground a, first}
    output logic [3:0]      core1_route,
    output logic [3:0]      core2_route,
    output logic [3:0]      core3_route,
    output logic [3:0]      core4_route,
    // Analog trims
    output logic [5:0]      full_scale_trim,
    output logic            low_clk_freq_active,
    output logic [2:0]      startup_sel_active
);

    // ======================================================================
    // Helpers
    function automatic logic [3:0] route_decode(input logic [4:0] sel);
        logic [3:0] r;
        r = sel[4:1];
        if (sel[0] || (r == 4'h0) || ((r & (r - 4'h1)) != 4'h0))
        begin
            r = 4'h0;
        end
        return r;
    endfunction

    // ======================================================================
    // Pin synchronisers
    logic [2:0] sclk_sync_reg;
    logic [1:0] ssel_sync_reg;
    logic [1:0] sdat_sync_reg;
    logic [1:0] pd_sync_reg;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sclk_sync_reg <= 3'h0;
            ssel_sync_reg <= 2'h3;
            sdat_sync_reg <= 2'h0;
            pd_sync_reg   <= 2'h0;
        end
        else
        begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], ser_clk};
            ssel_sync_reg <= {ssel_sync_reg[0], ser_sel_n};
            sdat_sync_reg <= {sdat_sync_reg[0], ser_data};
            pd_sync_reg   <= {pd_sync_reg[0], power_down};
        end
    end

    logic sclk_rise;
    logic sel_active;
    assign sclk_rise  = sclk_sync_reg[1] && !sclk_sync_reg[2];
    assign sel_active = !ssel_sync_reg[1];

    // ======================================================================
    // Serial receiver: address then data, MSB first
    amc_pkg::amc_rx_state_t      rx_state_reg;
    logic [amc_pkg::FRAME_BITS-1:0] shift_reg;
    logic [4:0]                  bit_cnt_reg;
    logic                        commit_reg;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rx_state_reg <= amc_pkg::ST_IDLE;
            shift_reg    <= '0;
            bit_cnt_reg  <= 5'h00;
            commit_reg   <= 1'b0;
        end
        else
        begin
            commit_reg <= 1'b0;
            case (rx_state_reg)
                amc_pkg::ST_IDLE:
                begin
                    bit_cnt_reg <= 5'h00;
                    if (sel_active)
                    begin
                        rx_state_reg <= amc_pkg::ST_SHIFT;
                    end
                end
                amc_pkg::ST_SHIFT:
                begin
                    if (!sel_active)
                    begin
                        // Short frame is dropped, nothing is applied
                        rx_state_reg <= amc_pkg::ST_IDLE;
                    end
                    else if (sclk_rise)
                    begin
                        shift_reg   <= {shift_reg[amc_pkg::FRAME_BITS-2:0], sdat_sync_reg[1]};
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                        if (bit_cnt_reg == 5'(amc_pkg::FRAME_BITS - 1))
                        begin
                            commit_reg   <= 1'b1;
                            rx_state_reg <= amc_pkg::ST_HOLD;
                        end
                    end
                end
                amc_pkg::ST_HOLD:
                begin
                    // Extra clocks in the same frame are ignored
                    if (!sel_active)
                    begin
                        rx_state_reg <= amc_pkg::ST_IDLE;
                    end
                end
                default:
                begin
                    rx_state_reg <= amc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    logic [7:0]  wr_addr;
    logic [15:0] wr_data;
    logic        soft_reset;
    assign wr_addr    = shift_reg[23:16];
    assign wr_data    = shift_reg[15:0];
    assign soft_reset = commit_reg && (wr_addr == amc_pkg::ADDR_SOFT_RESET)
                        && wr_data[amc_pkg::SOFT_RESET_BIT];

    // ======================================================================
    // Stored registers; written whole at commit, power-down does not block
    logic [2:0] mode_reg;
    logic [1:0] div_reg;
    logic [4:0] sel1_reg;
    logic [4:0] sel2_reg;
    logic [4:0] sel3_reg;
    logic [4:0] sel4_reg;
    logic       low_clk_reg;
    logic       early_reg;
    logic       late_reg;
    logic [5:0] fs_reg;
    logic [2:0] startup_reg;

    always_ff @(posedge clk)
    begin
        if (!rst_n || soft_reset) // R8
        begin
            mode_reg    <= amc_pkg::MODE_RST;
            div_reg     <= amc_pkg::DIV_RST; // R14
            sel1_reg    <= amc_pkg::SEL1_RST; // R16
            sel2_reg    <= amc_pkg::SEL2_RST;
            sel3_reg    <= amc_pkg::SEL3_RST;
            sel4_reg    <= amc_pkg::SEL4_RST;
            low_clk_reg <= 1'b0; // R1
            early_reg   <= 1'b0;
            late_reg    <= 1'b0;
            fs_reg      <= amc_pkg::FS_RST; // R20
            startup_reg <= amc_pkg::STARTUP_RST;
        end
        else if (commit_reg) // R6 R21
        begin
            case (wr_addr)
                amc_pkg::ADDR_MODE:
                begin
                    mode_reg <= wr_data[amc_pkg::MODE_LSB +: 3]; // R9
                    div_reg  <= wr_data[amc_pkg::DIV_LSB +: 2]; // R14
                end
                amc_pkg::ADDR_INSEL_A:
                begin
                    sel1_reg <= wr_data[amc_pkg::SEL_LO_LSB +: 5]; // R16
                    sel2_reg <= wr_data[amc_pkg::SEL_HI_LSB +: 5];
                end
                amc_pkg::ADDR_INSEL_B:
                begin
                    sel3_reg <= wr_data[amc_pkg::SEL_LO_LSB +: 5]; // R16
                    sel4_reg <= wr_data[amc_pkg::SEL_HI_LSB +: 5];
                end
                amc_pkg::ADDR_OUT_TIMING:
                begin
                    low_clk_reg <= wr_data[amc_pkg::LOW_CLK_BIT]; // R1
                    early_reg   <= wr_data[amc_pkg::EARLY_BIT];
                    late_reg    <= wr_data[amc_pkg::LATE_BIT];
                end
                amc_pkg::ADDR_FS_TRIM:
                begin
                    fs_reg <= wr_data[amc_pkg::FS_LSB +: 6]; // R20
                end
                amc_pkg::ADDR_STARTUP:
                begin
                    startup_reg <= wr_data[amc_pkg::STARTUP_LSB +: 3];
                end
                default:
                begin
                    // Unmapped addresses are ignored here
                end
            endcase
        end
    end

    // ======================================================================
    // Fields that need a power-down cycle take effect while the pin is high
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            low_clk_freq_active <= 1'b0;
            startup_sel_active  <= amc_pkg::STARTUP_RST;
        end
        else if (pd_sync_reg[1]) // R7
        begin
            low_clk_freq_active <= low_clk_reg; // R1
            startup_sel_active  <= startup_reg;
        end
    end

    // ======================================================================
    // Mode and channel grouping
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            single_mode      <= 1'b0;
            dual_mode        <= 1'b0;
            mode_unsupported <= 1'b1;
            core_channel     <= 4'h0;
        end
        else
        begin
            single_mode      <= (mode_reg == amc_pkg::MODE_SINGLE); // R9
            dual_mode        <= (mode_reg == amc_pkg::MODE_DUAL);
            mode_unsupported <= (mode_reg != amc_pkg::MODE_SINGLE)
                                && (mode_reg != amc_pkg::MODE_DUAL);
            // Bit n gives the channel of core n+1
            core_channel     <= (mode_reg == amc_pkg::MODE_DUAL) ? 4'hC : 4'h0; // R10
        end
    end

    // ======================================================================
    // Crosspoint: one cycle after the stored select changes, two after the last bit; illegal codes open
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            core1_route <= route_decode(amc_pkg::SEL1_RST);
            core2_route <= route_decode(amc_pkg::SEL2_RST);
            core3_route <= route_decode(amc_pkg::SEL3_RST);
            core4_route <= route_decode(amc_pkg::SEL4_RST);
        end
        else
        begin
            core1_route <= route_decode(sel1_reg); // R15 R17
            core2_route <= route_decode(sel2_reg);
            core3_route <= route_decode(sel3_reg);
            core4_route <= route_decode(sel4_reg);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            full_scale_trim <= amc_pkg::FS_RST;
        end
        else
        begin
            full_scale_trim <= fs_reg; // R20
        end
    end

    // ======================================================================
    // Sampling clock divider
    logic [1:0] div_cnt_reg;
    logic [1:0] div_top;
    always_comb
    begin
        case (div_reg) // R13
            amc_pkg::DIV_BY_2: div_top = amc_pkg::DIV_CNT_2;
            amc_pkg::DIV_BY_4: div_top = amc_pkg::DIV_CNT_4;
            default:           div_top = amc_pkg::DIV_CNT_1;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            div_cnt_reg   <= 2'h0;
            sample_strobe <= 1'b0;
        end
        else
        begin
            // Restarting at a new factor avoids a long first period
            div_cnt_reg   <= (div_cnt_reg >= div_top) ? 2'h0 : div_cnt_reg + 2'h1; // R13
            sample_strobe <= (div_cnt_reg == 2'h0);
        end
    end

    // ======================================================================
    // Output timing: normal path is two cycles, early one, late three
    logic [1:0] bit_tap_reg;
    logic [1:0] frame_tap_reg;
    logic [1:0] tap_sel;
    assign tap_sel = early_reg ? 2'h0 : (late_reg ? 2'h2 : 2'h1);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            bit_tap_reg      <= 2'h0;
            frame_tap_reg    <= 2'h0;
            stream_bit_out   <= 1'b0;
            stream_frame_out <= 1'b0;
        end
        else
        begin
            bit_tap_reg      <= {bit_tap_reg[0], stream_bit_in};
            frame_tap_reg    <= {frame_tap_reg[0], stream_frame_in};
            stream_bit_out   <= (tap_sel == 2'h0) ? stream_bit_in : bit_tap_reg[tap_sel[1]]; // R2 R3
            stream_frame_out <= (tap_sel == 2'h0) ? stream_frame_in
                                : frame_tap_reg[tap_sel[1]]; // R2 R3
        end
    end

endmodule

`default_nettype wire

// ### tb/amc_properties.sv
// Port checker for the converter configuration block
`timescale 1ns/100ps
`default_nettype none

module amc_properties
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // Pins
    input wire logic       ser_sel_n,
    input wire logic       power_down,
    input wire logic       stream_frame_in,
    input wire logic       stream_frame_out,
    // Status
    input wire logic       single_mode,
    input wire logic       dual_mode,
    input wire logic       mode_unsupported,
    input wire logic [3:0] core_channel,
    input wire logic [3:0] core1_route,
    input wire logic [3:0] core4_route,
    input wire logic [5:0] full_scale_trim,
    input wire logic       low_clk_freq_active,
    input wire logic [2:0] startup_sel_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ======================================================================
    // Helpers: recent power-down level and cycles since a frame
    logic [5:0] pd_hist;
    logic [4:0] since_sel;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pd_hist   <= 6'h00;
            since_sel <= 5'h1F;
        end
        else
        begin
            pd_hist   <= {pd_hist[4:0], power_down};
            since_sel <= !ser_sel_n ? 5'h00 : since_sel + {4'h0, since_sel != 5'h1F};
        end
    end

    // ======================================================================
    // Properties
    sequence s_trim_hold;
        $stable(full_scale_trim) [*8];
    endsequence
    sequence s_route_hold;
        ($stable(core1_route) && $stable(core4_route)) [*8];
    endsequence
    property p_mode_onehot;
        $onehot({single_mode, dual_mode, mode_unsupported});
    endproperty
    property p_dual_pairs;
        core_channel == (dual_mode ? 4'hC : 4'h0);
    endproperty
    property p_route_code;
        $onehot0(core1_route) && $onehot0(core4_route);
    endproperty
    property p_shift_window;
        stream_frame_out == $past(stream_frame_in) || stream_frame_out ==
        $past(stream_frame_in, 2) || stream_frame_out == $past(stream_frame_in, 3);
    endproperty
    property p_trim_atomic;
        $changed(full_scale_trim) |=> s_trim_hold;
    endproperty
    property p_route_atomic;
        $changed(core1_route) || $changed(core4_route) |=> s_route_hold;
    endproperty
    property p_route_after_frame;
        $changed(core1_route) || $changed(full_scale_trim) |-> since_sel < 5'h0C;
    endproperty
    property p_lowclk_by_pd;
        $changed(low_clk_freq_active) || $changed(startup_sel_active) |-> |pd_hist;
    endproperty
    a_mode_onehot: assert property (p_mode_onehot)
        else $error("mode flags not one-hot");
    a_dual_pairs: assert property (p_dual_pairs)
        else $error("core channel map wrong");
    a_route_code: assert property (p_route_code)
        else $error("route not one-hot");
    a_shift_window: assert property (p_shift_window)
        else $error("frame delay outside window");
    a_trim_atomic: assert property (p_trim_atomic)
        else $error("trim changed twice");
    a_route_atomic: assert property (p_route_atomic)
        else $error("route changed twice");
    a_route_after_frame: assert property (p_route_after_frame)
        else $error("change without a frame");
    a_lowclk_by_pd: assert property (p_lowclk_by_pd)
        else $error("active copy changed outside power-down");
endmodule

bind amc_config_top amc_properties amc_properties_inst
(
    .clk, .rst_n, .ser_sel_n, .power_down, .stream_frame_in, .stream_frame_out,
    .single_mode, .dual_mode, .mode_unsupported, .core_channel, .core1_route,
    .core4_route, .full_scale_trim, .low_clk_freq_active, .startup_sel_active
);

`default_nettype wire

// ### tb/amc_serial_host.sv
// Serial control host model that programs the configuration block
`timescale 1ns/100ps
`default_nettype none

module amc_serial_host
(
    // Clock
    input wire logic clk,
    // Serial control pins
    output logic     ser_sel_n,
    output logic     ser_clk,
    output logic     ser_data
);
    initial
    begin
        ser_sel_n = 1'b1;
        ser_clk   = 1'b0;
        ser_data  = 1'b0;
    end

    // ======================================================================
    // Unassigned positions always go out as zero; unmapped places get none
    function automatic logic [15:0] field_mask(input logic [7:0] a);
        case (a)
            8'h00: return 16'h0001;
            8'h31: return 16'h0307;
            8'h3A, 8'h3B: return 16'h1F1F;
            8'h53: return 16'h0038;
            8'h55: return 16'h003F;
            8'h56: return 16'h0007;
            default: return 16'h0000;
        endcase
    endfunction

    // Serial clock stands low between frames
    task automatic xfer(input logic [7:0] a, input logic [15:0] d);
        logic [23:0] f;
        f = {a, d & field_mask(a)};
        // A place missing from the map is never framed at all
        if (field_mask(a) != 16'h0000)
        begin
            @(posedge clk);
            ser_sel_n <= 1'b0;
            for (int i = 23; i >= 0; i--)
            begin
                ser_clk  <= 1'b0;
                ser_data <= f[i];
                repeat (3) @(posedge clk);
                ser_clk <= 1'b1;
                repeat (3) @(posedge clk);
            end
            ser_clk  <= 1'b0;
            ser_data <= ~f[0];
            repeat (3) @(posedge clk);
            ser_sel_n <= 1'b1;
            repeat (4) @(posedge clk);
        end
    endtask
endmodule

`default_nettype wire

// ### tb/adc_mode_and_input_config_test.sv
// Self-checking bench for the converter configuration block
`timescale 1ns/100ps
`default_nettype none

module adc_mode_and_input_config_test;
    logic       clk = 1'b0, rst_n = 1'b0, power_down = 1'b0;
    logic       bit_in = 1'b0, frm_in = 1'b0;
    logic       ser_sel_n, ser_clk, ser_data, bit_out, frm_out, strobe;
    logic       single, dual, unsup, lclk;
    logic [3:0] chan, route [4];
    logic [5:0] trim;
    logic [2:0] su_act, hb = 3'h0, hf = 3'h0;
    int         err_total = 0, compares = 0, seed = 41;
    int         md, dv, ot, fs, su, lca, sua, sel [4];
    int         codes [6] = '{2, 4, 8, 16, 3, 0};

    always #25 clk = ~clk;

    // ======================================================================
    // Stream stimulus and its history, newest first
    always @(posedge clk)
    begin
        hb <= {hb[1:0], bit_in};
        hf <= {hf[1:0], frm_in};
        if (rst_n)
        begin
            bit_in <= 1'($random(seed));
            frm_in <= 1'($random(seed));
        end
    end

    amc_serial_host host_inst (.clk, .ser_sel_n, .ser_clk, .ser_data);
    amc_config_top amc_config_top_inst
    (
        .clk, .rst_n, .ser_sel_n, .ser_clk, .ser_data, .power_down,
        .stream_bit_in(bit_in), .stream_frame_in(frm_in), .stream_bit_out(bit_out),
        .stream_frame_out(frm_out), .sample_strobe(strobe), .single_mode(single),
        .dual_mode(dual), .mode_unsupported(unsup), .core_channel(chan),
        .core1_route(route[0]), .core2_route(route[1]), .core3_route(route[2]),
        .core4_route(route[3]), .full_scale_trim(trim), .low_clk_freq_active(lclk),
        .startup_sel_active(su_act)
    );

    // ======================================================================
    // Model and checks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        if (err_total == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    function automatic logic [3:0] rt(input int c);
        case (c)
            2: return 4'h1;
            4: return 4'h2;
            8: return 4'h4;
            16: return 4'h8;
            default: return 4'h0;
        endcase
    endfunction

    task automatic defaults;
        md = 4;
        dv = 0;
        ot = 0;
        fs = 32;
        su = 0;
        sel = '{2, 4, 4, 16};
    endtask

    task automatic check_all;
        int n;
        n = 0;
        @(negedge clk);
        chk(single, md == 1);
        chk(dual, md == 2);
        chk(unsup, md != 1 && md != 2);
        chk(chan, md == 2 ? 4'hC : 4'h0);
        for (int i = 0; i < 4; i++)
            chk(route[i], rt(sel[i]));
        chk(trim, fs[5:0]);
        chk(lclk, lca[0]);
        chk(su_act, sua[2:0]);
        repeat (16) @(negedge clk) n += strobe;
        chk(n, dv == 1 ? 8 : dv == 2 ? 4 : 16);
        // Hand back on a rising edge so callers drive inputs there
        @(posedge clk);
    endtask

    task automatic wr(input int a, input int d);
        host_inst.xfer(a[7:0], d[15:0]);
        if (a == 8'h00 && d[0]) defaults();
        if (a == 8'h31) md = d[2:0];
        if (a == 8'h31) dv = d[9:8];
        if (a == 8'h3A) sel[0] = d[4:0];
        if (a == 8'h3A) sel[1] = d[12:8];
        if (a == 8'h3B) sel[2] = d[4:0];
        if (a == 8'h3B) sel[3] = d[12:8];
        if (a == 8'h53) ot = d[5:3];
        if (a == 8'h55) fs = d[5:0];
        if (a == 8'h56) su = d[2:0];
        check_all();
    endtask

    task automatic pcyc;
        power_down <= 1'b1;
        repeat (6) @(posedge clk);
        power_down <= 1'b0;
        repeat (6) @(posedge clk);
        lca = ot[0];
        sua = su;
        check_all();
    endtask

    task automatic shift_check(input int early, input int late);
        int k;
        wr(8'h53, early * 16 + late * 32);
        k = early ? 0 : late ? 2 : 1;
        repeat (12)
        begin
            @(negedge clk);
            chk(bit_out, hb[k]);
            chk(frm_out, hf[k]);
        end
    endtask

    // ======================================================================
    // Main sequence
    initial
    begin
        defaults();
        lca = 0;
        sua = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        check_all();
        for (int m = 1; m <= 4; m *= 2)
            for (int v = 0; v < 4; v++)
                wr(8'h31, m + v * 256);
        pcyc();
        power_down <= 1'b1;
        for (int i = 0; i < 6; i++)
            wr(8'h3A + i % 2, codes[{$random(seed)} % 6] + codes[{$random(seed)} % 6] * 256);
        power_down <= 1'b0;
        wr(8'h31, 2);
        wr(8'h3A, 16'h0202);
        wr(8'h3B, 16'h1010);
        pcyc();
        wr(8'h31, 1);
        wr(8'h3A, 16'h1010);
        pcyc();
        for (int i = 0; i < 4; i++)
            wr(8'h55, {$random(seed)} % 64);
        wr(8'h53, 8);
        wr(8'h56, 5);
        pcyc();
        for (int i = 0; i < 4; i++)
            shift_check(i % 2, i / 2);
        pcyc();
        wr(8'h40, 16'hFFFF);
        wr(8'h00, 1);
        pcyc();
        give_verdict();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        give_verdict();
    end
endmodule

`default_nettype wire
